// ### psr_pkg.sv
// shared constants, state codes and behaviour notes for the pressure target
// Notes on behaviour
// RL1: output value refreshed from a corrected 13-bit sample about every 500 us.
// RL2: device is target only; drives data line solely to answer the master.
// RL3: an idle bus leaves both lines released high.
// RL4: master opens each first request with START: data falls, clock high.
// RL5: only the master ends a transfer with STOP: data rises, clock high.
// RL6: several requests may follow without STOP; each one is served.
// RL7: data changes only while clock is low; one clock pulse per bit.
// RL8: transfers are 8-bit bytes, most significant bit first.
// RL9: receiver pulls data low on a ninth pulse to acknowledge each byte.
// RL10: missing master acknowledge stops device sending; master repeats or stops.
// RL11: device answers the fixed address 1111000.
// RL12: an optional second factory address is answered besides the fixed one.
// RL13: address byte is 7-bit address then direction bit, 1 meaning read.
// RL14: a read returns two bytes holding the latest 15-bit pressure count.
// RL15: count is 3277 at minimum pressure, span 26214 up to full scale.
// RL16: master clocks the bus between 100 kHz and 400 kHz; the bench master model uses a 260 ns bit period.
// RL17: unmatched address gets no acknowledge; bus ignored until next START.
package psr_pkg;
  localparam int SYS_PERIOD_NS = 8;
  localparam int REFRESH_NS    = 500_000;
  localparam int REFRESH_CYC   = REFRESH_NS / SYS_PERIOD_NS;
  localparam int CODE_BITS     = 13;
  localparam int COUNT_BITS    = 15;
  localparam int BYTE_BITS     = 8;
  localparam int ADDR_BITS     = 7;
  localparam int SYNC_DEPTH    = 3;

  localparam logic [ADDR_BITS-1:0]  MAIN_ADDR       = 7'h78;
  localparam logic [COUNT_BITS-1:0] MIN_COUNT       = 15'h0ccd;
  localparam logic [COUNT_BITS-1:0] FULL_SCALE_SPAN = 15'h6666;
  localparam logic [COUNT_BITS-1:0] PRESSURE_RST    = MIN_COUNT;
  localparam logic [3:0]            BYTE_LEN        = 4'h8;
  localparam logic [3:0]            BIT_CNT_RST     = 4'h0;
  localparam logic [BYTE_BITS-1:0]  TX_RST          = 8'hff;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_AACK = 8'h04,
    ST_TX   = 8'h08,
    ST_MACK = 8'h10,
    ST_RX   = 8'h20,
    ST_RACK = 8'h40,
    ST_SKIP = 8'h80
  } psr_state_t;
endpackage: psr_pkg

// ### psr_data_if.sv
// carrier between the sampler, the link capture and the protocol core
`timescale 1ns/1ps
`default_nettype none

interface psr_data_if;
  import psr_pkg::*;
  logic [COUNT_BITS-1:0] pressure;
  logic                  fresh;
  logic [BYTE_BITS-1:0]  lineByte;

  modport sampler (output pressure, output fresh);
  modport link    (output lineByte);
  modport core    (input pressure, input fresh, input lineByte);
endinterface: psr_data_if

`default_nettype wire

// ### psr_sampler.sv
// cyclic refresh of the corrected pressure count
`timescale 1ns/1ps
`default_nettype none

module psr_sampler
  import psr_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC
)(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 clkEn,
  input  wire logic [CODE_BITS-1:0] code,
  psr_data_if.sampler               dat
);
  localparam int TW = $clog2(REFRESH_CYCLES + 1);
  localparam logic [TW-1:0] TOP = TW'(REFRESH_CYCLES - 1);

  logic [TW-1:0]                   timer_ff;
  logic [COUNT_BITS-1:0]           value_ff;
  logic                            fresh_ff;
  logic [CODE_BITS+COUNT_BITS-1:0] prod;
  logic [COUNT_BITS-1:0]           nxt_value;
  logic [TW-1:0]                   gap_ff;
  logic                            seen_ff;

  // map the 13-bit code onto the count range above the zero offset
  assign prod      = code * FULL_SCALE_SPAN;
  assign nxt_value = MIN_COUNT + prod[CODE_BITS+COUNT_BITS-1:CODE_BITS]; // see RL15

  // refresh period timer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      timer_ff <= '0;
    end else if (clkEn) begin
      timer_ff <= (timer_ff == TOP) ? '0 : timer_ff + 1'b1;
    end
  end

  // output register, loaded once per period
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      value_ff <= PRESSURE_RST;
      fresh_ff <= 1'b0;
    end else if (clkEn) begin
      fresh_ff <= (timer_ff == TOP);
      if (timer_ff == TOP) begin
        value_ff <= nxt_value; // see RL1
      end
    end
  end

  assign dat.pressure = value_ff;
  assign dat.fresh    = fresh_ff;

  // gap counter watched by the checks only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gap_ff  <= '0;
      seen_ff <= 1'b0;
    end else if (clkEn) begin
      gap_ff  <= fresh_ff ? '0 : gap_ff + 1'b1;
      seen_ff <= seen_ff | fresh_ff;
    end
  end

  chk_refresh_gap: assert property ( // see RL1
    @(posedge sys_clk) disable iff (!resetn)
    fresh_ff && seen_ff |-> gap_ff == TOP)
    else $error("refresh spacing wrong");

  chk_count_range: assert property ( // see RL15
    @(posedge sys_clk) disable iff (!resetn)
    value_ff >= MIN_COUNT && value_ff <= MIN_COUNT + FULL_SCALE_SPAN)
    else $error("pressure count out of range");
endmodule: psr_sampler

`default_nettype wire

// ### psr_link_rx.sv
// bit capture on the bus clock
`timescale 1ns/1ps
`default_nettype none

module psr_link_rx
  import psr_pkg::*;
(
  input  wire logic sclClk,
  input  wire logic resetn,
  input  wire logic sdaIn,
  psr_data_if.link  dat
);
  logic [BYTE_BITS-1:0] shift_ff;

  // shift in on each rising bus clock; first bit ends on top
  always_ff @(posedge sclClk or negedge resetn) begin
    if (!resetn) begin
      shift_ff <= '0;
    end else begin
      shift_ff <= {shift_ff[BYTE_BITS-2:0], sdaIn}; // see RL8
    end
  end

  assign dat.lineByte = shift_ff;
endmodule: psr_link_rx

`default_nettype wire

// ### psr_i2c_target.sv
// two-wire target that serves the pressure count
`timescale 1ns/1ps
`default_nettype none

module psr_i2c_target
  import psr_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC
)(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 clkEn,
  input  wire logic                 sclClk,
  input  wire logic                 sdaIn,
  output logic                      sdaOut,
  output logic                      sdaOe,
  input  wire logic                 altAddrEn,
  input  wire logic [ADDR_BITS-1:0] altAddr,
  input  wire logic [CODE_BITS-1:0] sampleCode
);

  psr_data_if dat ();

  logic [SYNC_DEPTH-1:0] sclSync_ff;
  logic [SYNC_DEPTH-1:0] sdaSync_ff;
  logic                  sclRise;
  logic                  sclFall;
  logic                  sclHigh;
  logic                  startDet;
  logic                  stopDet;
  psr_state_t            state_ff;
  psr_state_t            nxt_state;
  logic [3:0]            bitCnt_ff;
  logic                  byteDone;
  logic                  addrHit;
  logic                  rdReq_ff;
  logic                  lastByte_ff;
  logic                  ackOk_ff;
  logic [COUNT_BITS-1:0] snap_ff;
  logic [BYTE_BITS-1:0]  txShift_ff;
  logic [BYTE_BITS-1:0]  nxt_txShift;
  logic                  sdaOe_ff;
  logic                  nxt_sdaOe;

  // refresh of the pressure value
  psr_sampler #(
    .REFRESH_CYCLES (REFRESH_CYCLES)
  ) u_sampler (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .code    (sampleCode),
    .dat     (dat.sampler)
  );

  // data capture in the bus clock domain
  psr_link_rx u_link (
    .sclClk (sclClk),
    .resetn (resetn),
    .sdaIn  (sdaIn),
    .dat    (dat.link)
  );

  // pin synchronisers; bit 0 feeds only bit 1
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclSync_ff <= '1;
      sdaSync_ff <= '1;
    end else if (clkEn) begin
      sclSync_ff <= {sclSync_ff[1:0], sclClk};
      sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
    end
  end

  // edges and bus conditions from the settled copies
  assign sclRise  = sclSync_ff[1] & ~sclSync_ff[2];
  assign sclFall  = ~sclSync_ff[1] & sclSync_ff[2];
  assign sclHigh  = sclSync_ff[1] & sclSync_ff[2];
  assign startDet = sclHigh & sdaSync_ff[2] & ~sdaSync_ff[1]; // see RL4
  assign stopDet  = sclHigh & ~sdaSync_ff[2] & sdaSync_ff[1]; // see RL5

  assign byteDone = (bitCnt_ff == BYTE_LEN);

  // address match; the captured byte is stable while the clock is low
  assign addrHit = (dat.lineByte[BYTE_BITS-1:1] == MAIN_ADDR) // see RL11
                 | (altAddrEn &
                    (dat.lineByte[BYTE_BITS-1:1] == altAddr)); // see RL12

  // protocol sequence, advanced on falling clock edges
  always_comb begin
    nxt_state = state_ff;
    if (stopDet) begin
      nxt_state = ST_IDLE; // see RL5
    end else if (startDet) begin
      nxt_state = ST_ADDR; // see RL6
    end else if (sclFall) begin
      case (state_ff)
        ST_ADDR: begin
          if (byteDone) begin
            nxt_state = addrHit ? ST_AACK : ST_SKIP; // see RL17
          end
        end
        ST_AACK: begin
          nxt_state = rdReq_ff ? ST_TX : ST_RX; // see RL13
        end
        ST_TX: begin
          if (byteDone) begin
            nxt_state = ST_MACK;
          end
        end
        ST_MACK: begin
          if (ackOk_ff && !lastByte_ff) begin
            nxt_state = ST_TX;
          end else begin
            nxt_state = ST_SKIP; // see RL10
          end
        end
        ST_RX: begin
          if (byteDone) begin
            nxt_state = ST_RACK;
          end
        end
        ST_RACK: begin
          nxt_state = ST_RX;
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  // bit counter: rising edges within a byte, cleared on each step
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bitCnt_ff <= BIT_CNT_RST;
    end else if (clkEn) begin
      if (startDet || (sclFall && nxt_state != state_ff)) begin
        bitCnt_ff <= BIT_CNT_RST;
      end else if (sclRise && (state_ff == ST_ADDR ||
                   state_ff == ST_TX || state_ff == ST_RX)) begin
        bitCnt_ff <= bitCnt_ff + 4'h1; // see RL7
      end
    end
  end

  // direction and value snapshot when the address is taken
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdReq_ff <= 1'b0;
      snap_ff  <= PRESSURE_RST;
    end else if (clkEn) begin
      if (state_ff == ST_ADDR && sclFall && byteDone && addrHit) begin
        rdReq_ff <= dat.lineByte[0]; // see RL13
        snap_ff  <= dat.pressure; // see RL14
      end
    end
  end

  // master acknowledge sampled at the ninth rising edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ackOk_ff <= 1'b0;
    end else if (clkEn) begin
      if (state_ff == ST_MACK && sclRise) begin
        ackOk_ff <= ~sdaSync_ff[1]; // see RL9
      end
    end
  end

  // transmit byte: high part first, then low part
  always_comb begin
    nxt_txShift = txShift_ff;
    if (sclFall && state_ff == ST_AACK) begin
      nxt_txShift = {1'b0, snap_ff[COUNT_BITS-1:BYTE_BITS]}; // see RL14
    end else if (sclFall && state_ff == ST_MACK) begin
      nxt_txShift = snap_ff[BYTE_BITS-1:0];
    end else if (sclFall && state_ff == ST_TX) begin
      nxt_txShift = {txShift_ff[BYTE_BITS-2:0], 1'b1}; // see RL8
    end
  end

  // byte order tracker for the two-byte answer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txShift_ff  <= TX_RST;
      lastByte_ff <= 1'b0;
    end else if (clkEn) begin
      txShift_ff <= nxt_txShift;
      if (sclFall && state_ff == ST_AACK) begin
        lastByte_ff <= 1'b0;
      end else if (sclFall && state_ff == ST_MACK) begin
        lastByte_ff <= 1'b1;
      end
    end
  end

  // data line drive, only in answer to the master
  always_comb begin
    case (nxt_state)
      ST_AACK, ST_RACK: nxt_sdaOe = 1'b1; // see RL9
      ST_TX:            nxt_sdaOe = ~nxt_txShift[BYTE_BITS-1];
      default:          nxt_sdaOe = 1'b0; // see RL2
    endcase
  end

  // drive register, changes one cycle after a settled falling edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sdaOe_ff <= 1'b0; // see RL3
    end else if (clkEn) begin
      sdaOe_ff <= nxt_sdaOe; // see RL7
    end
  end

  assign sdaOe  = sdaOe_ff;
  assign sdaOut = 1'b0; // open drain: only ever pulls low

  // checks in the system clock domain
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  chk_idle_released: assert property ( // see RL3
    state_ff == ST_IDLE || state_ff == ST_SKIP |-> !sdaOe)
    else $error("data line driven while idle");

  chk_target_only: assert property ( // see RL2
    sdaOe |-> state_ff inside {ST_AACK, ST_RACK, ST_TX})
    else $error("data line driven outside an answer");

  chk_start_restart: assert property ( // see RL6
    clkEn && startDet |=> state_ff == ST_ADDR && bitCnt_ff == BIT_CNT_RST)
    else $error("start not served");

  chk_stop_idle: assert property ( // see RL5
    clkEn && stopDet |=> state_ff == ST_IDLE && !sdaOe)
    else $error("stop not obeyed");

  chk_scl_high_hold: assert property ( // see RL7
    clkEn && sclHigh && !startDet && !stopDet |=> $stable(sdaOe))
    else $error("data changed while clock high");

  chk_addr_accept: assert property ( // see RL11
    clkEn && state_ff == ST_ADDR && sclFall && byteDone &&
    (dat.lineByte[7:1] == MAIN_ADDR ||
     (altAddrEn && dat.lineByte[7:1] == altAddr))
    |=> state_ff == ST_AACK && sdaOe)
    else $error("own address not acknowledged");

  chk_addr_miss: assert property ( // see RL17
    clkEn && state_ff == ST_ADDR && sclFall && byteDone && !addrHit
    |=> state_ff == ST_SKIP && !sdaOe)
    else $error("foreign address acknowledged");

  chk_ack_hold: assert property ( // see RL9
    clkEn && state_ff == ST_ADDR && sclFall && byteDone && addrHit
    |=> sdaOe throughout (state_ff == ST_AACK) [*2])
    else $error("acknowledge released early");

  chk_first_byte: assert property ( // see RL14
    clkEn && state_ff == ST_AACK && sclFall && rdReq_ff
    |=> state_ff == ST_TX && sdaOe && !lastByte_ff)
    else $error("first answer bit not the zero pad");

  chk_msb_order: assert property ( // see RL8
    clkEn && state_ff == ST_TX && sclFall && !byteDone
    |=> sdaOe == ~$past(txShift_ff[6]))
    else $error("bit order wrong");

  chk_nack_quit: assert property ( // see RL10
    clkEn && state_ff == ST_MACK && sclFall && !ackOk_ff
    |=> state_ff == ST_SKIP ##1 !sdaOe)
    else $error("sending continued after missing acknowledge");

  chk_rx_ack: assert property ( // see RL9
    clkEn && state_ff == ST_RX && sclFall && byteDone
    |=> state_ff == ST_RACK && sdaOe)
    else $error("received byte not acknowledged");

  chk_second_byte: assert property ( // see RL14
    clkEn && state_ff == ST_MACK && sclFall && ackOk_ff && !lastByte_ff
    |=> state_ff == ST_TX && sdaOe == ~snap_ff[7] && lastByte_ff)
    else $error("second answer byte not started");

  chk_freeze_hold: assert property ( // see RL2
    !clkEn |=> $stable(state_ff) && $stable(sdaOe))
    else $error("state moved while clock enable low");

  cov_two_byte_read: cover property (
    state_ff == ST_MACK && lastByte_ff && sclFall && ackOk_ff);

  cov_repeat_start: cover property (
    startDet && state_ff != ST_IDLE);

  cov_addr_miss: cover property (
    state_ff == ST_ADDR && sclFall && byteDone && !addrHit);

  cov_write_ack: cover property (
    state_ff == ST_RACK && sclFall);

  cov_refresh_in_frame: cover property (
    dat.fresh && state_ff != ST_IDLE);

endmodule: psr_i2c_target

`default_nettype wire

// ### psr_bus_master.sv
// two-wire bus master model: makes the bus clock and pulls data low
`timescale 1ns/1ps
`default_nettype none

module psr_bus_master #(
  parameter int QTR_NS = 65 // off the system clock grid on purpose
)(
  input  wire logic sdaWire,
  output var  logic sclLine,
  output var  logic sdaLow
);
  // both lines released at time zero, clock stands high until the first start
  initial begin
    sclLine = 1'h1;
    sdaLow  = 1'h0;
  end

  // start or repeated start: data falls while clock is high
  task automatic start();
    sdaLow = 1'h0;
    #QTR_NS sclLine = 1'h1;
    #QTR_NS sdaLow = 1'h1;
    #QTR_NS sclLine = 1'h0;
  endtask: start

  // stop: data rises while clock is high
  task automatic stop();
    #QTR_NS sdaLow = 1'h1;
    #QTR_NS sclLine = 1'h1;
    #QTR_NS sdaLow = 1'h0;
    #QTR_NS;
  endtask: stop

  // one bit: data moves mid low phase, sampled mid high phase
  task automatic bitx(input logic b, output logic got);
    #QTR_NS sdaLow = ~b;
    #QTR_NS sclLine = 1'h1;
    #QTR_NS got = sdaWire;
    #QTR_NS sclLine = 1'h0;
  endtask: bitx

  // one byte msb first plus the ninth acknowledge pulse
  task automatic xfer(input logic [7:0] tx, input logic ackIn,
                      output logic [7:0] rx, output logic ackOut);
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
    bitx(ackIn, ackOut);
  endtask: xfer
endmodule: psr_bus_master

`default_nettype wire

// ### test_pressure_sensor_i2c_readout.sv
// self-checking bench for the pressure two-wire target
`timescale 1ns/1ps
`default_nettype none

module test_pressure_sensor_i2c_readout
  import psr_pkg::*;
;
  localparam int REFRESH = 50;
  localparam int LIMIT   = 20000;
  // count for the full-scale code: 3277 plus 26210
  localparam logic [COUNT_BITS-1:0] TOP_COUNT = 15'h732f;

  logic                 sys_clk;
  logic                 resetn;
  logic                 clkEn;
  logic                 sclClk;
  logic                 mLow;
  logic                 sdaWire;
  logic                 sdaOut;
  logic                 sdaOe;
  logic                 altAddrEn;
  logic [ADDR_BITS-1:0] altAddr;
  logic [CODE_BITS-1:0] sampleCode;
  logic [7:0]           rx;
  logic                 ack;
  int                   n_mismatch;
  int                   checks_done;
  int                   cycles;

  // open-drain wire with pull-up
  assign sdaWire = ~(sdaOe | mLow);

  psr_i2c_target #(.REFRESH_CYCLES(REFRESH)) i_dut (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .clkEn     (clkEn),
    .sclClk    (sclClk),
    .sdaIn     (sdaWire),
    .sdaOut    (sdaOut),
    .sdaOe     (sdaOe),
    .altAddrEn (altAddrEn),
    .altAddr   (altAddr),
    .sampleCode(sampleCode)
  );

  psr_bus_master i_master (
    .sdaWire(sdaWire),
    .sclLine(sclClk),
    .sdaLow (mLow)
  );

  // system clock
  initial sys_clk = 1'h0;
  always #4 sys_clk = ~sys_clk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask: test_done

  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      test_done();
    end
  end

  // device output may move only while the bus clock is low
  always @(sdaOe) begin
    if (resetn === 1'h1 && sclClk === 1'h1) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, sclClk, 1'h0);
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask: chk8

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask: chk1

  // new code, then wait past two refresh periods
  task automatic setCode(input logic [CODE_BITS-1:0] c);
    @(posedge sys_clk) sampleCode <= c;
    repeat (2 * REFRESH + 4) @(posedge sys_clk);
  endtask: setCode

  // start, address for read, two bytes when acknowledged, no stop
  task automatic rdFrame(input logic [6:0] a, input logic ackExp,
                         input logic [COUNT_BITS-1:0] cnt);
    i_master.start();
    i_master.xfer({a, 1'h1}, 1'h1, rx, ack);
    chk1(ack, ackExp);
    if (ackExp == 1'h0) begin
      i_master.xfer(8'hff, 1'h0, rx, ack);
      chk8(rx, {1'h0, cnt[14:8]});
      i_master.xfer(8'hff, 1'h1, rx, ack);
      chk8(rx, cnt[7:0]);
    end
  endtask: rdFrame

  task automatic t_idle();
    repeat (20) @(negedge sys_clk);
    chk1(sdaWire, 1'h1);
    chk1(sdaOe, 1'h0);
    chk1(sdaOut, 1'h0);
    $display("t_idle done");
  endtask: t_idle

  // codes at both ends and mid, two requests without stop each
  task automatic t_read();
    logic [CODE_BITS-1:0]  codes  [3];
    logic [COUNT_BITS-1:0] counts [3];
    codes  = '{13'h0000, 13'h1000, 13'h1fff};
    counts = '{15'h0ccd, 15'h4000, TOP_COUNT};
    foreach (codes[i]) begin
      setCode(codes[i]);
      rdFrame(MAIN_ADDR, 1'h0, counts[i]);
      rdFrame(MAIN_ADDR, 1'h0, counts[i]);
      i_master.stop();
    end
    $display("t_read done");
  endtask: t_read

  task automatic t_addr();
    rdFrame(7'h79, 1'h1, '0);
    i_master.xfer(8'hff, 1'h1, rx, ack);
    chk8(rx, 8'hff);
    i_master.stop();
    @(posedge sys_clk) altAddrEn <= 1'h1;
    rdFrame(7'h2a, 1'h0, TOP_COUNT);
    rdFrame(MAIN_ADDR, 1'h0, TOP_COUNT);
    i_master.stop();
    @(posedge sys_clk) altAddrEn <= 1'h0;
    rdFrame(7'h2a, 1'h1, '0);
    i_master.stop();
    $display("t_addr done");
  endtask: t_addr

  // master refuses the first byte, device goes quiet
  task automatic t_nack();
    i_master.start();
    i_master.xfer({MAIN_ADDR, 1'h1}, 1'h1, rx, ack);
    chk1(ack, 1'h0);
    i_master.xfer(8'hff, 1'h1, rx, ack);
    chk8(rx, {1'h0, TOP_COUNT[14:8]});
    i_master.xfer(8'hff, 1'h1, rx, ack);
    chk8(rx, 8'hff);
    i_master.stop();
    $display("t_nack done");
  endtask: t_nack

  // device as receiver acknowledges every byte
  task automatic t_write();
    i_master.start();
    i_master.xfer({MAIN_ADDR, 1'h0}, 1'h1, rx, ack);
    chk1(ack, 1'h0);
    i_master.xfer(8'h55, 1'h1, rx, ack);
    chk1(ack, 1'h0);
    i_master.xfer(8'ha3, 1'h1, rx, ack);
    chk1(ack, 1'h0);
    i_master.stop();
    $display("t_write done");
  endtask: t_write

  // clock enable low: device frozen and silent, then serves again
  task automatic t_freeze();
    @(posedge sys_clk) clkEn <= 1'h0;
    i_master.start();
    i_master.xfer({MAIN_ADDR, 1'h1}, 1'h1, rx, ack);
    chk1(ack, 1'h1);
    i_master.stop();
    @(posedge sys_clk) clkEn <= 1'h1;
    repeat (4) @(posedge sys_clk);
    rdFrame(MAIN_ADDR, 1'h0, TOP_COUNT);
    i_master.stop();
    $display("t_freeze done");
  endtask: t_freeze

  // reset, then scenarios in turn
  initial begin
    resetn = 1'h0;
    clkEn = 1'h1;
    altAddrEn = 1'h0;
    altAddr = 7'h2a;
    sampleCode = 13'h0000;
    n_mismatch = 0;
    checks_done = 0;
    cycles = 0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (8) @(posedge sys_clk);
    t_idle();
    t_read();
    t_addr();
    t_nack();
    t_write();
    t_freeze();
    test_done();
  end
endmodule: test_pressure_sensor_i2c_readout

`default_nettype wire
